// *** scsc_defs.vh ***
`ifndef SCSC_DEFS_VH
`define SCSC_DEFS_VH

// ----------------------------------------------------------------
// register addresses
// ----------------------------------------------------------------
`define SCSC_ADDR_PIN_MODE     20'hfffa0
`define SCSC_ADDR_OSC_STATUS   20'hfffa1
`define SCSC_ADDR_SYS_SELECT   20'hfffa4
`define SCSC_ADDR_FAST_OSC     20'hfffa8

// ----------------------------------------------------------------
// reset values
// ----------------------------------------------------------------
`define SCSC_RST_PIN_MODE      8'h00
`define SCSC_RST_OSC_STATUS    8'hc0
`define SCSC_RST_SYS_SELECT    8'h09
`define SCSC_RST_FAST_OSC      8'h00

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define SCSC_BIT_EXT_CLK_SEL   7
`define SCSC_BIT_OSC_SEL       6
`define SCSC_BIT_SUB_PIN_MODE  4
`define SCSC_BIT_AMP_GAIN      0
`define SCSC_BIT_HS_STOP       7
`define SCSC_BIT_SUB_STOP      6
`define SCSC_BIT_INT_STOP      0
`define SCSC_BIT_MAIN_SEL      4
`define SCSC_BIT_MAIN_STATUS   5
`define SCSC_BIT_FAST_EN       0
`define SCSC_BIT_FAST_SEL      2
`define SCSC_BIT_WDT_EN_OPT    4
`define SCSC_BIT_WDT_STBY_OPT  0

// ----------------------------------------------------------------
// pin modes of the high-speed pins
// ----------------------------------------------------------------
`define SCSC_HS_MODE_PORT0     2'b00
`define SCSC_HS_MODE_XTAL      2'b01
`define SCSC_HS_MODE_PORT1     2'b10
`define SCSC_HS_MODE_EXT       2'b11

`endif

// *** scsc_sync.v ***
`timescale 1ns/1ns
// two-stage synchroniser for one level from outside the clock domain
module scsc_sync (
  input  wire i_clock,
  input  wire i_resetn,
  input  wire i_enable,
  input  wire i_async,
  output wire o_sync
);
  reg meta_r;
  reg sync_r;

  // first stage feeds only the second stage
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      meta_r <= 1'b0;
      sync_r <= 1'b0;
    end else if (i_enable) begin
      meta_r <= i_async;
      sync_r <= meta_r;
    end
  end

  assign o_sync = sync_r;
endmodule

// *** scsc_glitchless_mux.v ***
`timescale 1ns/1ns
// glitch-free two-way clock switch; the select only moves the gates
// while the clock they guard is low, so no phase is ever cut short
module scsc_glitchless_mux (
  input  wire i_resetn,
  input  wire i_clk_a,
  input  wire i_clk_b,
  input  wire i_sel_b,
  output wire o_clk
);
  reg a_en_m_r;
  reg a_en_r;
  reg b_en_m_r;
  reg b_en_r;

  // gate for clock a: opens only after b is closed
  always @(negedge i_clk_a or negedge i_resetn) begin
    if (!i_resetn) begin
      a_en_m_r <= 1'b1;
      a_en_r   <= 1'b1;
    end else begin
      a_en_m_r <= ~i_sel_b & ~b_en_r;
      a_en_r   <= a_en_m_r;
    end
  end

  // gate for clock b: opens only after a is closed
  always @(negedge i_clk_b or negedge i_resetn) begin
    if (!i_resetn) begin
      b_en_m_r <= 1'b0;
      b_en_r   <= 1'b0;
    end else begin
      b_en_m_r <= i_sel_b & ~a_en_r;
      b_en_r   <= b_en_m_r;
    end
  end

  assign o_clk = (i_clk_a & a_en_r) | (i_clk_b & b_en_r);
endmodule

// *** scsc_clock_control.v ***
`timescale 1ns/1ns
`include "scsc_defs.vh"
// Summary of operation
// R1 - high-speed crystal stops on stop mode or high-speed stop bit 7
// R2 - 8 MHz internal oscillator runs after reset; 40 MHz stays off
// R3 - 8 MHz oscillator stops on stop mode or internal stop bit 0
// R4 - 40 MHz oscillator follows fast enable bit 0
// R5 - external 2-20 MHz clock input disabled by stop mode or bit 7
// R6 - main clock select bit 4: 1 high-speed, 0 internal high-speed
// R7 - fast clock select bit 2 swaps in 40 MHz as internal source
// R8 - 32.768 kHz subsystem crystal stops when subsystem stop bit 6 set
// R9 - 30 kHz low-speed clock feeds only the watchdog, never the cpu
// R10 - low-speed oscillator stops whenever the watchdog is stopped
// R11 - watchdog stopped if enable option 0, or standby without run option
// R12 - pin-mode register takes only the first write after reset
// R13 - pin-mode register is readable at any time
// R14 - every reset clears the pin-mode register to zero
// R15 - high-speed pin mode: 00/10 port, 01 crystal, 11 external clock
// R16 - subsystem pin mode 0 leaves both subsystem pins as ports
// R17 - pin-mode register bit 0 sets high-speed oscillator gain
// R18 - software sets gain bit above 10 MHz, clears it from 2 to 10 MHz
// R19 - reset stops both crystals and keeps 8 MHz oscillator running
// R20 - software never sets internal stop while 40 MHz is enabled
// R21 - source switching never shortens a clock phase
module scsc_clock_control (
  input  wire        i_clock,
  input  wire        i_resetn,
  input  wire        i_clk_en,
  // register port
  input  wire [19:0] i_addr,
  input  wire [7:0]  i_wdata,
  input  wire        i_write,
  input  wire        i_read,
  output reg  [7:0]  o_rdata,
  // processor state and option byte
  input  wire        i_stop_mode,
  input  wire        i_halt_mode,
  input  wire [7:0]  i_option_byte,
  // clock sources
  input  wire        i_hs_clk,
  input  wire        i_ih_clk,
  input  wire        i_ih40_clk,
  // oscillator enables
  output reg         o_x1_osc_en,
  output reg         o_ext_clk_en,
  output reg         o_ih_osc_en,
  output reg         o_ih40_osc_en,
  output reg         o_sub_osc_en,
  output reg         o_low_osc_en,
  output reg         o_wdt_clk_en,
  output reg         o_x1_amp_gain,
  // pin modes
  output reg         o_x1_pin_osc,
  output reg         o_x2_pin_ext,
  output reg         o_sub_pin_osc,
  // main clock
  output wire        o_main_clk,
  output reg         o_main_is_hs
);

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [7:0] pin_mode_r;
  reg       pin_mode_locked_r;
  reg [7:0] osc_status_r;
  reg [7:0] sys_select_r;
  reg [7:0] fast_osc_r;
  reg [7:0] rdata_nxt;
  wire      stop_s;
  wire      halt_s;
  wire      sel_hs;
  wire      sel_ih40;
  wire      ih_side_clk;
  wire      wdt_stopped;

  // ----------------------------------------------------------------
  // processor mode levels come from another block; synchronise them
  // ----------------------------------------------------------------
  scsc_sync u_stop_sync (
    .i_clock  (i_clock),
    .i_resetn (i_resetn),
    .i_enable (i_clk_en),
    .i_async  (i_stop_mode),
    .o_sync   (stop_s)
  );

  scsc_sync u_halt_sync (
    .i_clock  (i_clock),
    .i_resetn (i_resetn),
    .i_enable (i_clk_en),
    .i_async  (i_halt_mode),
    .o_sync   (halt_s)
  );

  // ----------------------------------------------------------------
  // pin-mode and gain register, written once per reset
  // ----------------------------------------------------------------
  // reserved bits stay zero so a read shows only real fields
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      pin_mode_r        <= `SCSC_RST_PIN_MODE; // R14
      pin_mode_locked_r <= 1'b0;
    end else if (i_clk_en) begin
      if (i_write && i_addr == `SCSC_ADDR_PIN_MODE && !pin_mode_locked_r) begin
        pin_mode_r        <= i_wdata & 8'hd1; // R12
        pin_mode_locked_r <= 1'b1;            // R12
      end
    end
  end

  // ----------------------------------------------------------------
  // control registers
  // ----------------------------------------------------------------
  // status bit 5 of the select register is read-only, derived below
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      osc_status_r <= `SCSC_RST_OSC_STATUS; // R19
      sys_select_r <= `SCSC_RST_SYS_SELECT;
      fast_osc_r   <= `SCSC_RST_FAST_OSC;   // R2
    end else if (i_clk_en && i_write) begin
      case (i_addr)
        `SCSC_ADDR_OSC_STATUS: begin
          osc_status_r <= i_wdata & 8'hc1;
        end
        `SCSC_ADDR_SYS_SELECT: begin
          sys_select_r <= (i_wdata & 8'h57) | 8'h08;
        end
        `SCSC_ADDR_FAST_OSC: begin
          fast_osc_r <= i_wdata & 8'h05;
        end
        default: begin
          osc_status_r <= osc_status_r;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // read port: data stand in the cycle after the strobe
  // ----------------------------------------------------------------
  always @* begin
    rdata_nxt = 8'h00;
    case (i_addr)
      `SCSC_ADDR_PIN_MODE:   rdata_nxt = pin_mode_r; // R13
      `SCSC_ADDR_OSC_STATUS: rdata_nxt = osc_status_r;
      `SCSC_ADDR_SYS_SELECT: begin
        rdata_nxt = sys_select_r;
        rdata_nxt[`SCSC_BIT_MAIN_STATUS] = o_main_is_hs;
      end
      `SCSC_ADDR_FAST_OSC:   rdata_nxt = fast_osc_r;
      default:               rdata_nxt = 8'h00;
    endcase
  end

  // unmapped reads return zero; data held only one cycle
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_rdata <= 8'h00;
    end else if (i_clk_en) begin
      o_rdata <= i_read ? rdata_nxt : 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // watchdog run state
  // ----------------------------------------------------------------
  assign wdt_stopped = !i_option_byte[`SCSC_BIT_WDT_EN_OPT] ||
                       ((halt_s || stop_s) &&
                        !i_option_byte[`SCSC_BIT_WDT_STBY_OPT]); // R11

  // ----------------------------------------------------------------
  // oscillator enables and pin modes, registered
  // ----------------------------------------------------------------
  // the crystal only runs when its pins are wired as a resonator
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_x1_osc_en   <= 1'b0;
      o_ext_clk_en  <= 1'b0;
      o_ih_osc_en   <= 1'b1; // R2
      o_ih40_osc_en <= 1'b0;
      o_sub_osc_en  <= 1'b0;
      o_low_osc_en  <= 1'b0;
      o_wdt_clk_en  <= 1'b0;
      o_x1_amp_gain <= 1'b0;
      o_x1_pin_osc  <= 1'b0;
      o_x2_pin_ext  <= 1'b0;
      o_sub_pin_osc <= 1'b0;
    end else if (i_clk_en) begin
      o_x1_pin_osc  <= {pin_mode_r[`SCSC_BIT_EXT_CLK_SEL],
                        pin_mode_r[`SCSC_BIT_OSC_SEL]} == `SCSC_HS_MODE_XTAL; // R15
      o_x2_pin_ext  <= {pin_mode_r[`SCSC_BIT_EXT_CLK_SEL],
                        pin_mode_r[`SCSC_BIT_OSC_SEL]} == `SCSC_HS_MODE_EXT;  // R15
      o_sub_pin_osc <= pin_mode_r[`SCSC_BIT_SUB_PIN_MODE];                    // R16
      o_x1_amp_gain <= pin_mode_r[`SCSC_BIT_AMP_GAIN];                        // R17
      o_x1_osc_en   <= !stop_s && !osc_status_r[`SCSC_BIT_HS_STOP] &&
                       o_x1_pin_osc;                                          // R1
      o_ext_clk_en  <= !stop_s && !osc_status_r[`SCSC_BIT_HS_STOP] &&
                       o_x2_pin_ext;                                          // R5
      o_ih_osc_en   <= !stop_s && !osc_status_r[`SCSC_BIT_INT_STOP];          // R3
      o_ih40_osc_en <= fast_osc_r[`SCSC_BIT_FAST_EN];                         // R4
      o_sub_osc_en  <= !osc_status_r[`SCSC_BIT_SUB_STOP] && o_sub_pin_osc;    // R8
      o_low_osc_en  <= !wdt_stopped;                                          // R10
      o_wdt_clk_en  <= !wdt_stopped;                                          // R9
    end
  end

  // ----------------------------------------------------------------
  // main clock selection
  // ----------------------------------------------------------------
  // the low-speed clock has no path into this mux at all
  assign sel_hs   = sys_select_r[`SCSC_BIT_MAIN_SEL];  // R6
  assign sel_ih40 = fast_osc_r[`SCSC_BIT_FAST_SEL];    // R7

  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn) begin
      o_main_is_hs <= 1'b0;
    end else if (i_clk_en) begin
      o_main_is_hs <= sel_hs; // R6
    end
  end

  // two cascaded switches; each waits for a low phase before moving
  scsc_glitchless_mux u_ih_mux (
    .i_resetn (i_resetn),
    .i_clk_a  (i_ih_clk),
    .i_clk_b  (i_ih40_clk),
    .i_sel_b  (sel_ih40),
    .o_clk    (ih_side_clk)
  ); // R21

  scsc_glitchless_mux u_main_mux (
    .i_resetn (i_resetn),
    .i_clk_a  (ih_side_clk),
    .i_clk_b  (i_hs_clk),
    .i_sel_b  (sel_hs),
    .o_clk    (o_main_clk)
  ); // R21

endmodule

// *** scsc_osc_model.sv ***
`timescale 1ns/1ns
// resonators and oscillators outside the block; a stopped source holds low
module scsc_osc_model (
  input  wire i_hs_en,
  input  wire i_ih_en,
  input  wire i_ih40_en,
  output reg  o_hs_clk,
  output reg  o_ih_clk,
  output reg  o_ih40_clk
);
  // ----------------------------------------------------------------
  // free-running sources, gated by their enables
  // ----------------------------------------------------------------
  initial begin
    o_hs_clk = 1'b0;
    o_ih_clk = 1'b0;
    o_ih40_clk = 1'b0;
  end
  // 20 MHz is the top of the external range, so the fastest legal case
  always #25 o_hs_clk = i_hs_en ? ~o_hs_clk : 1'b0;
  always #63 o_ih_clk = i_ih_en ? ~o_ih_clk : 1'b0;
  always #13 o_ih40_clk = i_ih40_en ? ~o_ih40_clk : 1'b0;
endmodule

// *** scsc_clock_control_properties.sv ***
`timescale 1ns/1ns
module scsc_clock_control_properties (
  input wire        i_clock,
  input wire        i_resetn,
  input wire        i_clk_en,
  input wire [19:0] i_addr,
  input wire [7:0]  i_wdata,
  input wire        i_write,
  input wire        i_read,
  input wire [7:0]  o_rdata,
  input wire        i_stop_mode,
  input wire [7:0]  i_option_byte,
  input wire        o_x1_osc_en,
  input wire        o_ext_clk_en,
  input wire        o_ih_osc_en,
  input wire        o_ih40_osc_en,
  input wire        o_low_osc_en,
  input wire        o_wdt_clk_en,
  input wire        o_x1_pin_osc,
  input wire        o_x2_pin_ext
);
  // ----------------------------------------------------------------
  // helper logic
  // ----------------------------------------------------------------
  reg  pin_wrote_r;
  wire pin_wr = i_clk_en && i_write && i_addr == 20'hfffa0;
  // remembers the first pin-mode write, after which writes must bounce
  always @(posedge i_clock or negedge i_resetn) begin
    if (!i_resetn)
      pin_wrote_r <= 1'b0;
    else if (pin_wr)
      pin_wrote_r <= 1'b1;
  end
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  // ----------------------------------------------------------------
  // properties
  // ----------------------------------------------------------------
  rd_idle_zero_a: assert property (!$past(i_read) |-> o_rdata == 8'h00)
    else $error("read data not zero");
  pin_write_once_a: assert property (pin_wrote_r && pin_wr
    |=> ##1 $stable({o_x1_pin_osc, o_x2_pin_ext})) else $error("pin mode rewritten");
  wdt_off_a: assert property (!i_option_byte[4] && $stable(i_option_byte)
    |=> !o_low_osc_en && !o_wdt_clk_en) else $error("low osc runs");
  x1_mode_a: assert property (o_x1_osc_en |-> o_x1_pin_osc)
    else $error("crystal on outside crystal mode");
  ext_mode_a: assert property (o_ext_clk_en |-> o_x2_pin_ext && !o_x1_osc_en)
    else $error("external input outside its mode");
  fast_en_a: assert property (i_clk_en && i_write && i_addr == 20'hfffa8
    |=> ##1 o_ih40_osc_en == $past(i_wdata[0], 2)) else $error("fast osc enable");
  stop_all_a: assert property (i_stop_mode [*6]
    |-> !o_x1_osc_en && !o_ext_clk_en && !o_ih_osc_en) else $error("stop ignored");
  ih_release_a: assert property (!$past(i_resetn)
    |-> o_ih_osc_en && !o_ih40_osc_en) else $error("bad enables at release");
endmodule
bind scsc_clock_control scsc_clock_control_properties u_props (.*);

// *** scsc_clock_control_tb.sv ***
`timescale 1ns/1ns
module scsc_clock_control_tb;
  reg  [19:0] i_addr;
  reg  [7:0]  i_wdata, i_option_byte, pm;
  reg         i_clock, i_resetn, i_write, i_read, i_stop_mode, i_halt_mode, i_clk_en;
  wire [7:0]  o_rdata;
  wire        i_hs_clk, i_ih_clk, i_ih40_clk, o_main_clk, o_main_is_hs;
  wire        o_x1_osc_en, o_ext_clk_en, o_ih_osc_en, o_ih40_osc_en, o_sub_osc_en;
  wire        o_low_osc_en, o_wdt_clk_en, o_x1_amp_gain;
  wire        o_x1_pin_osc, o_x2_pin_ext, o_sub_pin_osc;
  integer     mismatches, num_checks, m;
  scsc_clock_control uut (.*);
  scsc_osc_model u_osc (
    .i_hs_en    (o_x1_osc_en | o_ext_clk_en),
    .i_ih_en    (o_ih_osc_en),
    .i_ih40_en  (o_ih40_osc_en),
    .o_hs_clk   (i_hs_clk),
    .o_ih_clk   (i_ih_clk),
    .o_ih40_clk (i_ih40_clk)
  );
  // ----------------------------------------------------------------
  // tasks
  // ----------------------------------------------------------------
  task check(input [7:0] seen, input [7:0] exp, input [8*8:1] what);
    begin
      num_checks = num_checks + 1;
      if (seen !== exp) begin
        mismatches = mismatches + 1;
        $display("ERROR %0s expected %h seen %h", what, exp, seen);
      end
    end
  endtask
  task wr(input [19:0] a, input [7:0] d);
    begin
      @(posedge i_clock);
      i_addr <= a;
      i_wdata <= d;
      i_write <= 1'b1;
      @(posedge i_clock);
      i_write <= 1'b0;
    end
  endtask
  // read data stands only in the cycle after the strobe
  task rd(input [19:0] a, input [7:0] exp, input [8*8:1] what);
    begin
      @(posedge i_clock);
      i_addr <= a;
      i_read <= 1'b1;
      @(posedge i_clock);
      i_read <= 1'b0;
      #1 check(o_rdata, exp, what);
    end
  endtask
  task settle;
    begin
      repeat (6) @(posedge i_clock);
      #1;
    end
  endtask
  task do_reset;
    begin
      @(posedge i_clock);
      i_resetn <= 1'b0;
      repeat (8) @(posedge i_clock);
      i_resetn <= 1'b1;
    end
  endtask
  // status bit follows the select register one cycle later, so poll under a bound
  task wait_hs(input v);
    begin
      repeat (60) if (o_main_is_hs !== v) @(posedge i_clock);
      #1 check(o_main_is_hs, v, "main_hs");
    end
  endtask
  task close_out;
    begin
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
        $display("ALL CHECKS OK");
      else
        $display("CHECKS NOT OK");
      $finish;
    end
  endtask
  // ----------------------------------------------------------------
  // clock, watchdog and tests
  // ----------------------------------------------------------------
  initial begin
    i_clock = 1'b0;
    forever #50 i_clock = ~i_clock;
  end
  // generous bound: the tests need well under a tenth of it
  initial begin
    #2000000;
    mismatches = mismatches + 1;
    close_out;
  end
  initial begin
    {i_resetn, i_write, i_read, i_stop_mode, i_halt_mode} = 5'h00;
    {i_addr, i_wdata, i_option_byte, pm} = 44'h0;
    i_clk_en = 1'b1;
    mismatches = 0;
    num_checks = 0;
    do_reset;
    rd(20'hfffa0, 8'h00, "pin");
    rd(20'hfffa1, 8'hc0, "status");
    rd(20'hfffa4, 8'h09, "select");
    rd(20'hfffa8, 8'h00, "fast");
    rd(20'hfffa2, 8'h00, "unmapped");
    check(o_ih_osc_en, 8'h01, "ih_en");
    check(o_x1_osc_en | o_ih40_osc_en, 8'h00, "x1_ih40");
    // every high-speed pin mode, each after a fresh reset
    for (m = 0; m < 4; m = m + 1) begin
      do_reset;
      // crystal mode gets high gain: the model's source runs above 10 MHz
      pm = {m[1:0], 1'b0, m[0], 3'h0, ~m[1]};
      wr(20'hfffa0, pm);
      wr(20'hfffa0, 8'hff);
      rd(20'hfffa0, pm, "pin");
      wr(20'hfffa1, 8'h00);
      settle;
      check(o_x1_pin_osc, m == 1, "x1_pin");
      check(o_x2_pin_ext, m == 3, "ext_pin");
      check(o_x1_osc_en, m == 1, "x1_en");
      check(o_ext_clk_en, m == 3, "ext_en");
      check({o_sub_pin_osc, o_sub_osc_en}, {2{m[0]}}, "sub");
      check(o_x1_amp_gain, !m[1], "gain");
      wr(20'hfffa1, 8'h80);
      settle;
      check(o_x1_osc_en | o_ext_clk_en, 8'h00, "hs_stop");
    end
    wr(20'hfffa1, 8'h40);
    settle;
    check({o_ext_clk_en, o_sub_osc_en}, 8'h02, "sub_stop");
    wr(20'hfffa4, 8'h19);
    wait_hs(1'b1);
    // the switch needs a few source edges; sample twice, half a source period apart
    settle;
    check(o_main_clk, i_hs_clk, "main_clk");
    #25 check(o_main_clk, i_hs_clk, "main_clk");
    rd(20'hfffa4, 8'h39, "select");
    wr(20'hfffa4, 8'h09);
    wait_hs(1'b0);
    wr(20'hfffa8, 8'h01);
    settle;
    check(o_ih40_osc_en, 8'h01, "ih40_en");
    wr(20'hfffa8, 8'h05);
    rd(20'hfffa8, 8'h05, "fast");
    wr(20'hfffa8, 8'h00);
    settle;
    check(o_ih40_osc_en, 8'h00, "ih40_en");
    // clock enable low: a write in that window must leave no trace
    @(posedge i_clock);
    i_clk_en <= 1'b0;
    wr(20'hfffa8, 8'h01);
    i_clk_en <= 1'b1;
    settle;
    check(o_ih40_osc_en, 8'h00, "ih40_frz");
    rd(20'hfffa8, 8'h00, "fast");
    wr(20'hfffa1, 8'h41);
    settle;
    check(o_ih_osc_en, 8'h00, "ih_en");
    wr(20'hfffa1, 8'h00);
    settle;
    @(posedge i_clock);
    i_stop_mode <= 1'b1;
    settle;
    check({o_ext_clk_en, o_ih_osc_en}, 8'h00, "stop");
    i_stop_mode <= 1'b0;
    // watchdog option and standby combinations
    for (m = 0; m < 4; m = m + 1) begin
      @(posedge i_clock);
      i_option_byte <= {3'h0, m != 0, 3'h0, m == 3};
      i_halt_mode <= m[1];
      settle;
      check({o_low_osc_en, o_wdt_clk_en}, {2{m[0]}}, "low_osc");
    end
    close_out;
  end
endmodule
